// File: flcms_defines.svh
`ifndef FLCMS_DEFINES_SVH
`define FLCMS_DEFINES_SVH

// Register byte offsets.
`define FLCMS_OFS_FRAME 5'h00
`define FLCMS_OFS_DIFF_ENERGY 5'h04
`define FLCMS_OFS_BAND_NORM 5'h08
`define FLCMS_OFS_LIMIT 5'h0c
`define FLCMS_OFS_STATUS 5'h10
`define FLCMS_OFS_BAND_RANGE 5'h14

// Frame register fields.
`define FLCMS_FRAME_BFI 0
`define FLCMS_FRAME_PREV_FD 1
`define FLCMS_FRAME_TRANSIENT 2

// Band norm register fields.
`define FLCMS_NORM_BAND_LSB 0
`define FLCMS_NORM_VALUE_LSB 16

// Band range register fields.
`define FLCMS_RANGE_LO_LSB 0
`define FLCMS_RANGE_HI_LSB 8

// Status register fields.
`define FLCMS_ST_MODE_LSB 0
`define FLCMS_ST_COUNT_LSB 8
`define FLCMS_ST_PHASE_EN 16
`define FLCMS_ST_PHASE_NEXT 17
`define FLCMS_ST_STAT_OUT 18
`define FLCMS_ST_STAT_OLD 19
`define FLCMS_ST_FD_ACTIVE 20
`define FLCMS_ST_PREV_BFI 21

// Energy thresholds in unsigned Q0.16, rounded up so that "below" stays exact.
`define FLCMS_STAT_THRESH 16'h083f
`define FLCMS_SMOOTH_THRESH 16'h28b9

// Reset values of the writable settings.
`define FLCMS_LIMIT_RESET 16'h1000
`define FLCMS_BAND_LO_RESET 5'h01
`define FLCMS_BAND_HI_RESET 5'h07

`define FLCMS_COUNT_MAX 4'hf

`endif

// File: flcms_pkg.sv
package flcms_pkg;

  typedef enum logic [3:0] {
    MODE_NORMAL,
    MODE_OVERLAP_ADD,
    MODE_PHASE_ERASED,
    MODE_PHASE_NEXT_GOOD,
    MODE_PHASE_BURST,
    MODE_REPSMOOTH_ERASED,
    MODE_REPSMOOTH_NEXT_GOOD,
    MODE_AFTER_BURST
  } flcms_mode_t;

  typedef struct packed {
    logic [4:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } flcms_avs_req_t;

  typedef struct packed {
    logic fdActive;
    logic specRepeat;
    logic invXform;
    logic overlapConv;
    logic frameDone;
  } flcms_ctl_t;

  typedef struct packed {
    logic waitReq;
    logic [31:0] rdata;
    flcms_mode_t mode;
    flcms_ctl_t ctl;
    logic [3:0] lostCnt;
    logic prevBfi;
    logic phaseEn;
    logic phaseNext;
    logic statOut;
    logic statOld;
    logic [4:0] prevMaxBand;
    logic [2:0] transHist;
    logic [15:0] maxNorm;
    logic [4:0] maxBand;
    logic [15:0] diffEnergy;
    logic [15:0] limit;
    logic [4:0] bandLo;
    logic [4:0] bandHi;
  } flcms_state_t;

endpackage : flcms_pkg

// File: flcms_mode_select.sv
`timescale 1ns/1ps
`include "flcms_defines.svh"

// What this block does
// - Frequency-domain concealment runs only for a bad frame after a frequency-domain frame.
// - A lost frame repeats the stored spectral coefficients of the last good frame.
// - The repeated coefficients go through the inverse transform.
// - Conventional overlap-add joins current and previous time-domain signals.
// - First: count one, phase enable set, continue clear selects phase for erased frame.
// - Else previous bad, current good, continue set selects phase for next good frame.
// - Else previous and current bad, continue set selects phase for burst losses.
// - Phase enable is computed on each good frame and governs the next loss.
// - Sub-band energies for arming come from the per-band norm values.
// - Arm only with low peak band, index step at most one, small change, no transients.
// - Current stationary flag is one when energy difference is below 0.032209.
// - Final flag follows current only when equal to stored; stored is overwritten each frame.
// - Erased frame, phase flags clear: stationary or difference below 0.159063 gives smoothing.
// - Non-stationary erased frame without phase alignment falls back to overlap-add.
// - First good frame after loss, stationary: smoothing for next good frame.
// - First good frame after loss, non-stationary, count above one: after-burst recovery.
// - First good frame after a single loss, non-stationary: conventional overlap-add.
module flcms_mode_select (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output flcms_pkg::flcms_mode_t concealMode,
  output flcms_pkg::flcms_ctl_t concealCtl
);

  flcms_pkg::flcms_state_t s_q;
  flcms_pkg::flcms_state_t s_d;
  flcms_pkg::flcms_avs_req_t req;

  logic accept;
  logic wrDone;
  logic go;
  logic bfi;
  logic statCurr;
  logic statFinal;
  logic stationary;
  logic [3:0] runCnt;
  logic [4:0] bandStep;
  logic [31:0] beMask;
  logic [31:0] status;

  assign req = '{address: avs_address, read: avs_read, write: avs_write,
                 writedata: avs_writedata, byteenable: avs_byteenable};
  // The slave answers one cycle after a request appears, so decode never meets the full path.
  assign accept = (req.read || req.write) && s_q.waitReq;
  assign wrDone = req.write && !s_q.waitReq;
  assign go = wrDone && (req.address == `FLCMS_OFS_FRAME);
  assign bfi = req.writedata[`FLCMS_FRAME_BFI];
  assign beMask = {{8{req.byteenable[3]}}, {8{req.byteenable[2]}},
                   {8{req.byteenable[1]}}, {8{req.byteenable[0]}}};

  assign statCurr = s_q.diffEnergy < `FLCMS_STAT_THRESH;
  assign statFinal = (s_q.statOld == statCurr) ? statCurr : s_q.statOut;
  assign stationary = statFinal || (s_q.diffEnergy < `FLCMS_SMOOTH_THRESH);
  // The count seen by selection includes the current frame when it is lost.
  assign runCnt = (bfi && s_q.lostCnt != `FLCMS_COUNT_MAX) ? s_q.lostCnt + 4'h1 : s_q.lostCnt;
  assign bandStep = (s_q.maxBand >= s_q.prevMaxBand) ? s_q.maxBand - s_q.prevMaxBand
                                                     : s_q.prevMaxBand - s_q.maxBand;

  always_comb begin
    status = 32'h0000_0000;
    status[`FLCMS_ST_MODE_LSB +: 4] = s_q.mode;
    status[`FLCMS_ST_COUNT_LSB +: 4] = s_q.lostCnt;
    status[`FLCMS_ST_PHASE_EN] = s_q.phaseEn;
    status[`FLCMS_ST_PHASE_NEXT] = s_q.phaseNext;
    status[`FLCMS_ST_STAT_OUT] = s_q.statOut;
    status[`FLCMS_ST_STAT_OLD] = s_q.statOld;
    status[`FLCMS_ST_FD_ACTIVE] = s_q.ctl.fdActive;
    status[`FLCMS_ST_PREV_BFI] = s_q.prevBfi;
  end

  always_comb begin
    s_d = s_q;
    s_d.waitReq = !accept;
    s_d.ctl.frameDone = 1'b0;
    if (accept && req.read) begin
      unique case (req.address)
        `FLCMS_OFS_DIFF_ENERGY: s_d.rdata = {16'h0000, s_q.diffEnergy};
        `FLCMS_OFS_BAND_NORM: s_d.rdata = {s_q.maxNorm, 11'h000, s_q.maxBand};
        `FLCMS_OFS_LIMIT: s_d.rdata = {16'h0000, s_q.limit};
        `FLCMS_OFS_STATUS: s_d.rdata = status;
        `FLCMS_OFS_BAND_RANGE: s_d.rdata = {19'h00000, s_q.bandHi, 3'h0, s_q.bandLo};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
    if (wrDone) begin
      unique case (req.address)
        `FLCMS_OFS_DIFF_ENERGY: begin
          s_d.diffEnergy = req.writedata[15:0] & beMask[15:0] | s_q.diffEnergy & ~beMask[15:0];
        end
        `FLCMS_OFS_LIMIT: begin
          s_d.limit = req.writedata[15:0] & beMask[15:0] | s_q.limit & ~beMask[15:0];
        end
        `FLCMS_OFS_BAND_RANGE: begin
          if (req.byteenable[0]) s_d.bandLo = req.writedata[`FLCMS_RANGE_LO_LSB +: 5];
          if (req.byteenable[1]) s_d.bandHi = req.writedata[`FLCMS_RANGE_HI_LSB +: 5];
        end
        `FLCMS_OFS_BAND_NORM: begin
          // Norms are log-energies, so the largest norm marks the highest-energy band.
          if (req.writedata[`FLCMS_NORM_VALUE_LSB +: 16] > s_q.maxNorm) begin
            s_d.maxNorm = req.writedata[`FLCMS_NORM_VALUE_LSB +: 16];
            s_d.maxBand = req.writedata[`FLCMS_NORM_BAND_LSB +: 5];
          end
        end
        default: begin
        end
      endcase
    end
    if (go) begin
      // Mode and controls change only here, so the mode stands for the whole frame; frameDone is cleared again the next cycle.
      s_d.ctl.frameDone = 1'b1;
      s_d.ctl.fdActive = bfi && req.writedata[`FLCMS_FRAME_PREV_FD];
      s_d.ctl.specRepeat = s_d.ctl.fdActive;
      s_d.ctl.invXform = s_d.ctl.fdActive;
      if (runCnt == 4'h1 && bfi && s_q.phaseEn && !s_q.phaseNext) begin
        s_d.mode = flcms_pkg::MODE_PHASE_ERASED;
      end else if (s_q.prevBfi && !bfi && s_q.phaseNext) begin
        s_d.mode = flcms_pkg::MODE_PHASE_NEXT_GOOD;
      end else if (s_q.prevBfi && bfi && s_q.phaseNext) begin
        s_d.mode = flcms_pkg::MODE_PHASE_BURST;
      end else if (bfi) begin
        s_d.mode = stationary ? flcms_pkg::MODE_REPSMOOTH_ERASED
                              : flcms_pkg::MODE_OVERLAP_ADD;
      end else if (s_q.prevBfi) begin
        if (stationary) begin
          s_d.mode = flcms_pkg::MODE_REPSMOOTH_NEXT_GOOD;
        end else if (runCnt > 4'h1) begin
          s_d.mode = flcms_pkg::MODE_AFTER_BURST;
        end else begin
          s_d.mode = flcms_pkg::MODE_OVERLAP_ADD;
        end
      end else begin
        s_d.mode = flcms_pkg::MODE_NORMAL;
      end
      s_d.ctl.overlapConv = (s_d.mode == flcms_pkg::MODE_OVERLAP_ADD) || s_d.ctl.fdActive;
      s_d.phaseNext = (s_d.mode == flcms_pkg::MODE_PHASE_ERASED) ||
                      (s_d.mode == flcms_pkg::MODE_PHASE_BURST);
      s_d.lostCnt = bfi ? runCnt : 4'h0;
      s_d.statOut = statFinal;
      s_d.statOld = statCurr;
      s_d.prevBfi = bfi;
      if (!bfi) begin
        // Arming happens at the good frame's memory update and serves the next loss.
        s_d.phaseEn = (s_q.maxBand >= s_q.bandLo) && (s_q.maxBand <= s_q.bandHi) &&
                      (bandStep <= 5'h01) && (s_q.diffEnergy < s_q.limit) &&
                      (s_q.transHist == 3'h0);
        s_d.prevMaxBand = s_q.maxBand;
        s_d.transHist = {s_q.transHist[1:0], req.writedata[`FLCMS_FRAME_TRANSIENT]};
      end
      s_d.maxNorm = 16'h0000;
      s_d.maxBand = 5'h00;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{waitReq: 1'b1, rdata: 32'h0000_0000, mode: flcms_pkg::MODE_NORMAL,
               ctl: '0, lostCnt: 4'h0, prevBfi: 1'b0, phaseEn: 1'b0,
               phaseNext: 1'b0, statOut: 1'b0, statOld: 1'b0, prevMaxBand: 5'h00,
               transHist: 3'h0, maxNorm: 16'h0000, maxBand: 5'h00,
               diffEnergy: 16'h0000, limit: `FLCMS_LIMIT_RESET,
               bandLo: `FLCMS_BAND_LO_RESET, bandHi: `FLCMS_BAND_HI_RESET};
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata = s_q.rdata;
  assign avs_waitrequest = s_q.waitReq;
  assign concealMode = s_q.mode;
  assign concealCtl = s_q.ctl;

  property p_fd_active;
    @(posedge clk) disable iff (!rst_n)
      go |=> concealCtl.fdActive == ($past(bfi) && $past(req.writedata[1]));
  endproperty
  a_fd_active: assert property (p_fd_active) else $error("fd path flag wrong");

  property p_xform;
    @(posedge clk) disable iff (!rst_n)
      concealCtl.fdActive |-> concealCtl.specRepeat && concealCtl.invXform &&
        concealCtl.overlapConv;
  endproperty
  a_xform: assert property (p_xform) else $error("fd datapath steps missing");

  property p_phase_erased;
    @(posedge clk) disable iff (!rst_n)
      go && bfi && s_q.lostCnt == 4'h0 && s_q.phaseEn && !s_q.phaseNext
        |=> concealMode == flcms_pkg::MODE_PHASE_ERASED ##1 s_q.phaseNext;
  endproperty
  a_phase_erased: assert property (p_phase_erased) else $error("phase erased not chosen");

  property p_phase_next;
    @(posedge clk) disable iff (!rst_n)
      go && !bfi && s_q.prevBfi && s_q.phaseNext
        |=> concealMode == flcms_pkg::MODE_PHASE_NEXT_GOOD && !s_q.phaseNext;
  endproperty
  a_phase_next: assert property (p_phase_next) else $error("phase next good not chosen");

  property p_phase_burst;
    @(posedge clk) disable iff (!rst_n)
      go && bfi && s_q.prevBfi && s_q.phaseNext && s_q.lostCnt != 4'h0
        |=> concealMode == flcms_pkg::MODE_PHASE_BURST;
  endproperty
  a_phase_burst: assert property (p_phase_burst) else $error("phase burst not chosen");

  property p_stat_curr;
    @(posedge clk) disable iff (!rst_n)
      go |=> s_q.statOld == ($past(s_q.diffEnergy) < `FLCMS_STAT_THRESH);
  endproperty
  a_stat_curr: assert property (p_stat_curr) else $error("stationary flag wrong");

  property p_hyst;
    @(posedge clk) disable iff (!rst_n)
      go && (s_q.statOld != statCurr) |=> s_q.statOut == $past(s_q.statOut);
  endproperty
  a_hyst: assert property (p_hyst) else $error("hysteresis not held");

  property p_count;
    @(posedge clk) disable iff (!rst_n)
      go && !bfi |=> s_q.lostCnt == 4'h0 ##1 (!go)[*1];
  endproperty
  a_count: assert property (p_count) else $error("run count not cleared");

  property p_hold;
    @(posedge clk) disable iff (!rst_n)
      !go |=> $stable(concealMode) && $stable(concealCtl.overlapConv);
  endproperty
  a_hold: assert property (p_hold) else $error("mode changed mid frame");

  property p_after_burst;
    @(posedge clk) disable iff (!rst_n)
      go && !bfi && s_q.prevBfi && !s_q.phaseNext && !stationary && s_q.lostCnt > 4'h1
        |=> concealMode == flcms_pkg::MODE_AFTER_BURST;
  endproperty
  a_after_burst: assert property (p_after_burst) else $error("after burst not chosen");

  property p_arm_needs_low_band;
    @(posedge clk) disable iff (!rst_n)
      go && !bfi && (s_q.maxBand > s_q.bandHi) |=> !s_q.phaseEn;
  endproperty
  a_arm_needs_low_band: assert property (p_arm_needs_low_band) else $error("armed off band");

  property p_rep_lost;
    @(posedge clk) disable iff (!rst_n)
      concealCtl.specRepeat |-> s_q.prevBfi;
  endproperty
  a_rep_lost: assert property (p_rep_lost) else $error("repeat without loss");

  property p_rs_erased;
    @(posedge clk) disable iff (!rst_n)
      go && bfi && !s_q.phaseNext && !(s_q.lostCnt == 4'h0 && s_q.phaseEn) && stationary
        |=> concealMode == flcms_pkg::MODE_REPSMOOTH_ERASED;
  endproperty
  a_rs_erased: assert property (p_rs_erased) else $error("smoothing not chosen");

  property p_fallback;
    @(posedge clk) disable iff (!rst_n)
      go && bfi && !s_q.phaseNext && !(s_q.lostCnt == 4'h0 && s_q.phaseEn) && !stationary
        |=> concealMode == flcms_pkg::MODE_OVERLAP_ADD && concealCtl.overlapConv;
  endproperty
  a_fallback: assert property (p_fallback) else $error("no overlap-add fallback");

  property p_rs_next;
    @(posedge clk) disable iff (!rst_n)
      go && !bfi && s_q.prevBfi && !s_q.phaseNext && stationary
        |=> concealMode == flcms_pkg::MODE_REPSMOOTH_NEXT_GOOD;
  endproperty
  a_rs_next: assert property (p_rs_next) else $error("next good smoothing missing");

  property p_single_loss;
    @(posedge clk) disable iff (!rst_n)
      go && !bfi && s_q.prevBfi && !s_q.phaseNext && !stationary && s_q.lostCnt == 4'h1
        |=> concealMode == flcms_pkg::MODE_OVERLAP_ADD;
  endproperty
  a_single_loss: assert property (p_single_loss) else $error("single loss not plain");

  property p_done_pulse;
    @(posedge clk) disable iff (!rst_n)
      go |=> concealCtl.frameDone ##1 !concealCtl.frameDone;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("frame done not one pulse");

  property p_count_inc;
    @(posedge clk) disable iff (!rst_n)
      go && bfi && s_q.lostCnt != `FLCMS_COUNT_MAX
        |=> s_q.lostCnt == $past(s_q.lostCnt) + 4'h1;
  endproperty
  a_count_inc: assert property (p_count_inc) else $error("run count not counted");

  property p_norm_max;
    @(posedge clk) disable iff (!rst_n)
      wrDone && req.address == `FLCMS_OFS_BAND_NORM &&
        req.writedata[`FLCMS_NORM_VALUE_LSB +: 16] > s_q.maxNorm
        |=> s_q.maxBand == $past(req.writedata[`FLCMS_NORM_BAND_LSB +: 5]);
  endproperty
  a_norm_max: assert property (p_norm_max) else $error("peak band not tracked");

  property p_arm_step;
    @(posedge clk) disable iff (!rst_n)
      go && !bfi && bandStep > 5'h01 |=> !s_q.phaseEn;
  endproperty
  a_arm_step: assert property (p_arm_step) else $error("armed on band jump");

  property p_arm_trans;
    @(posedge clk) disable iff (!rst_n)
      go && !bfi && s_q.transHist != 3'h0 |=> !s_q.phaseEn;
  endproperty
  a_arm_trans: assert property (p_arm_trans) else $error("armed after transient");

  property p_arm_keep;
    @(posedge clk) disable iff (!rst_n)
      go && bfi |=> $stable(s_q.phaseEn);
  endproperty
  a_arm_keep: assert property (p_arm_keep) else $error("armed on lost frame");

endmodule : flcms_mode_select

// File: flcms_frame_src.sv
`timescale 1ns/1ps

// Stands in for the frame decoder datapath that hands over loss flags, energies and norms.
// Norms are never zero, so a tie with the cleared maximum tracker cannot hide a band.
module flcms_frame_src;

  task automatic draw(output logic bfi, output logic pfd, output logic tr,
      output logic [15:0] diff, output logic [4:0] band, output logic [15:0] norm);
    bfi = ($urandom_range(2) == 0);
    pfd = 1'($urandom_range(1));
    tr = ($urandom_range(7) == 0);
    diff = ($urandom_range(1) == 1) ? 16'($urandom_range(16'h3000)) : 16'($urandom);
    band = 5'($urandom_range(9));
    norm = 16'($urandom_range(16'hffff, 1));
  endtask : draw

endmodule : flcms_frame_src

// File: flcms_mode_select_tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; $display("wrong value at %0t: %h, expected %h", $time, g, e); end end

module flcms_mode_select_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  flcms_pkg::flcms_mode_t concealMode;
  flcms_pkg::flcms_mode_t lastMode = flcms_pkg::MODE_NORMAL;
  flcms_pkg::flcms_ctl_t concealCtl;
  int failures = 0;
  int checked = 0;
  logic [31:0] rdQ[$];
  logic [8:0] frQ[$];
  // Reference state of the selector, advanced once per committed frame.
  logic [3:0] lost = 4'h0;
  logic pBfi = 1'b0, phEn = 1'b0, phNx = 1'b0, sOld = 1'b0, sOut = 1'b0;
  logic [4:0] pBand = 5'h0;
  logic [2:0] hist = 3'h0;
  logic [15:0] limit = 16'h1000;
  logic b, pf, tr;
  logic [15:0] df, nm;
  logic [4:0] bd;

  always #5 clk = ~clk;

  flcms_mode_select i_dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .concealMode(concealMode), .concealCtl(concealCtl));

  flcms_frame_src i_src ();

  // Each note is taken off exactly once, so one mismatch cannot shift later expectations.
  always @(posedge clk) begin : monitor
    logic [31:0] rdExp;
    logic [8:0] frExp;
    if (rst_n && avs_read && avs_waitrequest === 1'b0) begin
      rdExp = (rdQ.size() > 0) ? rdQ.pop_front() : 'x;
      `CHK(avs_readdata, rdExp)
    end
    if (rst_n && concealCtl.frameDone === 1'b1) begin
      frExp = (frQ.size() > 0) ? frQ.pop_front() : 'x;
      `CHK({concealMode, concealCtl}, frExp)
      lastMode = concealMode;
    end else if (rst_n) begin
      `CHK(concealMode, lastMode)
    end
  end

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  // One Avalon access; the request is held until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
      input logic [3:0] be, input logic [31:0] exp);
    int n;
    if (!wr) rdQ.push_back(exp);
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (n == 20) begin
      failures++;
      stop_test();
    end else begin
      avs_write <= 1'b0;
      avs_read <= 1'b0;
    end
  endtask : bus

  // Commits one frame and predicts mode, controls and status.
  task automatic fr(input logic b, input logic pf, input logic tr, input logic [15:0] df,
      input logic [4:0] bd, input logic [15:0] nm);
    logic st;
    logic fd;
    logic [3:0] c;
    flcms_pkg::flcms_mode_t m;
    // A lost frame carries no new spectrum, so its band never moves the arming test.
    if (b) bd = pBand;
    bus(1'b1, 5'h04, {16'h0, df}, 4'hf, 32'h0);
    bus(1'b1, 5'h08, {nm, 11'h0, bd}, 4'hf, 32'h0);
    if (sOld == (df < 16'h083f)) sOut = sOld;
    sOld = (df < 16'h083f);
    st = sOut || df < 16'h28b9;
    c = b ? (lost == 4'hf ? lost : lost + 4'h1) : lost;
    if (b && c == 4'h1 && phEn && !phNx) m = flcms_pkg::MODE_PHASE_ERASED;
    else if (pBfi && !b && phNx) m = flcms_pkg::MODE_PHASE_NEXT_GOOD;
    else if (pBfi && b && phNx) m = flcms_pkg::MODE_PHASE_BURST;
    else if (b) m = st ? flcms_pkg::MODE_REPSMOOTH_ERASED : flcms_pkg::MODE_OVERLAP_ADD;
    else if (pBfi) m = st ? flcms_pkg::MODE_REPSMOOTH_NEXT_GOOD :
      (c > 4'h1 ? flcms_pkg::MODE_AFTER_BURST : flcms_pkg::MODE_OVERLAP_ADD);
    else m = flcms_pkg::MODE_NORMAL;
    phNx = (m == flcms_pkg::MODE_PHASE_ERASED || m == flcms_pkg::MODE_PHASE_BURST);
    if (!b) begin
      phEn = bd >= 5'h01 && bd <= 5'h07 && (bd >= pBand ? bd - pBand : pBand - bd) <= 5'h01
        && df < limit && hist == 3'h0;
      pBand = bd;
      hist = {hist[1:0], tr};
    end
    fd = b && pf;
    frQ.push_back({m, fd, fd, fd, m == flcms_pkg::MODE_OVERLAP_ADD || fd, 1'b1});
    lost = b ? c : 4'h0;
    pBfi = b;
    bus(1'b1, 5'h00, {29'h0, tr, pf, b}, 4'hf, 32'h0);
    bus(1'b0, 5'h10, 32'h0, 4'hf,
      {10'h0, b, fd, sOld, sOut, phNx, phEn, 4'h0, lost, 4'h0, m});
  endtask : fr

  initial begin
    void'($urandom(27));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, 5'h0c, 32'h0, 4'hf, 32'h00001000);
    bus(1'b0, 5'h14, 32'h0, 4'hf, 32'h00000701);
    bus(1'b1, 5'h14, 32'h00001f09, 4'h2, 32'h0);
    bus(1'b0, 5'h14, 32'h0, 4'hf, 32'h00001f01);
    bus(1'b1, 5'h14, 32'h00000701, 4'h3, 32'h0);
    bus(1'b0, 5'h14, 32'h0, 4'hf, 32'h00000701);
    bus(1'b0, 5'h18, 32'h0, 4'hf, 32'h0);
    bus(1'b1, 5'h10, 32'hffffffff, 4'hf, 32'h0);
    bus(1'b0, 5'h10, 32'h0, 4'hf, 32'h0);
    bus(1'b1, 5'h04, 32'h0000abcd, 4'hf, 32'h0);
    bus(1'b1, 5'h04, 32'hffff0012, 4'h1, 32'h0);
    bus(1'b0, 5'h04, 32'h0, 4'hf, 32'h0000ab12);
    bus(1'b1, 5'h08, 32'h01000003, 4'hf, 32'h0);
    bus(1'b1, 5'h08, 32'h03000005, 4'hf, 32'h0);
    bus(1'b1, 5'h08, 32'h02000002, 4'hf, 32'h0);
    bus(1'b0, 5'h08, 32'h0, 4'hf, 32'h03000005);
    bus(1'b0, 5'h00, 32'h0, 4'hf, 32'h0);
    fr(0, 0, 0, 16'h4000, 5'h05, 16'h0300);
    repeat (4) fr(0, 0, 0, 16'h0100, 5'h03, 16'h0800);
    fr(1, 1, 0, 16'h0100, 5'h03, 16'h0800);
    fr(1, 0, 0, 16'h0100, 5'h03, 16'h0800);
    fr(0, 0, 0, 16'h0100, 5'h03, 16'h0800);
    repeat (2) fr(0, 0, 0, 16'h4000, 5'h03, 16'h0800);
    fr(1, 0, 0, 16'h4000, 5'h03, 16'h0800);
    fr(0, 0, 0, 16'h4000, 5'h03, 16'h0800);
    repeat (2) fr(1, 1, 0, 16'h4000, 5'h03, 16'h0800);
    fr(0, 0, 0, 16'h4000, 5'h03, 16'h0800);
    fr(1, 0, 0, 16'h28b8, 5'h03, 16'h0800);
    fr(0, 0, 0, 16'h28b9, 5'h03, 16'h0800);
    repeat (2) fr(0, 0, 0, 16'h083e, 5'h04, 16'h0800);
    fr(0, 0, 0, 16'h083f, 5'h06, 16'h0800);
    repeat (17) fr(1, 0, 0, 16'h4000, 5'h03, 16'h0800);
    bus(1'b1, 5'h0c, 32'h00000200, 4'hf, 32'h0);
    limit = 16'h0200;
    bus(1'b0, 5'h0c, 32'h0, 4'hf, 32'h00000200);
    fr(0, 0, 1, 16'h0100, 5'h07, 16'h0800);
    repeat (4) fr(0, 0, 0, 16'h01ff, 5'h08, 16'h0800);
    repeat (150) begin
      i_src.draw(b, pf, tr, df, bd, nm);
      fr(b, pf, tr, df, bd, nm);
    end
    repeat (3) @(posedge clk);
    // A result that never appeared leaves its note behind, which a hang must not hide.
    if (rdQ.size() != 0 || frQ.size() != 0) begin
      failures++;
      $display("wrong value at %0t: %0d results never appeared", $time, rdQ.size() + frQ.size());
    end
    stop_test();
  end

endmodule : flcms_mode_select_tb_top
